// ### hdl/async_serial_ctrl_status.sv
// Asynchronous serial controller: AXI4-Lite register file, status
// flags, flag-clearing sequence, wakeup and interrupt request.
// Assumes a push-pull transmit pin and an asynchronous receive pin.
`timescale 1ns/10ps
module async_serial_ctrl_status
  import serial_pkg::*;
#(
  parameter int          ADDR_W   = 8,
  parameter logic [12:0] BAUD_RST = 13'h001A
)
(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              rxd,
  output logic                   txd,
  output logic                   irq
);
  if (ADDR_W < 8) begin : g_addr_chk
    $error("ADDR_W must reach the register map");
  end

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  sb);
    merge16 = {sb[1] ? wd[15:8] : old[15:8], sb[0] ? wd[7:0] : old[7:0]};
  endfunction

  // Bus slave state
  logic [ADDR_W-1:0] aw_addr_r;
  logic              aw_hold_r;
  logic [31:0]       w_data_r;
  logic [3:0]        w_strb_r;
  logic              w_hold_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              rvalid_r;
  logic [1:0]        rresp_r;
  logic [31:0]       rdata_r;

  // Registers and flags
  logic [12:0] baud_r;
  logic [12:0] baud_cnt_r;
  logic [7:0]  ctrl_one_r;
  logic [7:0]  ctrl_two_r;
  logic [8:0]  tdr_r;
  logic [8:0]  rdr_r;
  logic [7:0]  flags_r;
  logic [7:0]  flags_nxt;
  logic [7:0]  arm_r;
  logic [7:0]  flag_set;
  logic [7:0]  flag_clr;
  logic        tx_act_d_r;
  logic        rxd_m_r;
  logic        rxd_s_r;
  logic        irq_r;

  // Sub-block wires
  logic        tick;
  logic        take;
  logic        tx_busy;
  logic        rx_done;
  logic [8:0]  rx_data;
  logic        rx_fe;
  logic        rx_nf;
  logic        rx_pe;
  logic        rx_idle;
  logic        rx_act;

  // Handshakes stall while the clock enable freezes the block
  assign s_axi_awready = ce && !aw_hold_r && !bvalid_r;
  assign s_axi_wready  = ce && !w_hold_r && !bvalid_r;
  assign s_axi_arready = ce && !rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;
  assign irq           = irq_r;

  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs  = s_axi_wvalid && s_axi_wready;
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  wire do_wr = ce && aw_hold_r && w_hold_r && !bvalid_r;

  // Write decode
  wire aw_baud = aw_addr_r == ADDR_W'(BAUD_OFS);
  wire aw_c1   = aw_addr_r == ADDR_W'(CTRL1_OFS);
  wire aw_s1   = aw_addr_r == ADDR_W'(STAT1_OFS);
  wire aw_c2   = aw_addr_r == ADDR_W'(CTRL2_OFS);
  wire aw_s2   = aw_addr_r == ADDR_W'(STAT2_OFS);
  wire aw_dat  = aw_addr_r == ADDR_W'(DATA_OFS);
  wire aw_ok   = aw_baud || aw_c1 || aw_s1 || aw_c2 || aw_s2 || aw_dat;
  wire wr_baud = do_wr && aw_baud;
  wire wr_c1   = do_wr && aw_c1;
  wire wr_c2   = do_wr && aw_c2;
  wire wr_data = do_wr && aw_dat && (|w_strb_r[1:0]);

  wire [15:0] m_baud = merge16({3'h0, baud_r}, w_data_r, w_strb_r);
  wire [15:0] m_c1   = merge16({8'h00, ctrl_one_r}, w_data_r, w_strb_r);
  wire [15:0] m_c2   = merge16({8'h00, ctrl_two_r}, w_data_r, w_strb_r);
  wire [15:0] m_dat  = merge16({7'h00, tdr_r}, w_data_r, w_strb_r);

  // Read decode
  wire ar_baud = s_axi_araddr == ADDR_W'(BAUD_OFS);
  wire ar_c1   = s_axi_araddr == ADDR_W'(CTRL1_OFS);
  wire ar_s1   = s_axi_araddr == ADDR_W'(STAT1_OFS);
  wire ar_c2   = s_axi_araddr == ADDR_W'(CTRL2_OFS);
  wire ar_s2   = s_axi_araddr == ADDR_W'(STAT2_OFS);
  wire ar_dat  = s_axi_araddr == ADDR_W'(DATA_OFS);
  wire ar_ok   = ar_baud || ar_c1 || ar_s1 || ar_c2 || ar_s2 || ar_dat;
  wire rd_stat1 = ce && ar_hs && ar_s1;
  wire [7:0] stat2 = 8'(rx_act) << S2_RAF;
  wire [31:0] rd_val = ar_baud ? {19'h0, baud_r} :
                       ar_c1   ? {24'h0, ctrl_one_r} :
                       ar_s1   ? {24'h0, flags_r} :
                       ar_c2   ? {24'h0, ctrl_two_r} :
                       ar_s2   ? {24'h0, stat2} :
                       ar_dat  ? {23'h0, rdr_r} : 32'h0;

  // Control fields
  wire tx_on      = ctrl_two_r[C2_TE];
  wire rx_on      = ctrl_two_r[C2_RE];
  wire rx_sleep   = ctrl_two_r[C2_RWU];
  wire word9      = ctrl_one_r[C1_M];
  wire wake_addr  = ctrl_one_r[C1_WAKE];
  wire parity_on  = ctrl_one_r[C1_PE];
  wire parity_odd = ctrl_one_r[C1_PT];
  wire brk_req    = wr_c2 && m_c2[C2_SBK];

  // Baud prescaler: one sample tick every baud_r cycles, zero acts as one
  assign tick = ({1'b0, baud_cnt_r} + 14'h0001) >= {1'b0, baud_r};

  // Receive acceptance and wakeup
  wire rx_msb   = word9 ? rx_data[8] : rx_data[7];
  wire wake_hit = rx_sleep && wake_addr && rx_done && rx_msb;
  wire accept   = rx_on && rx_done && (!rx_sleep || wake_hit);
  wire hw_wake  = wake_hit || (rx_sleep && !wake_addr && rx_idle);

  // Transmitter busy while any frame, preamble, break or data is pending
  wire tx_act = tx_busy || (tx_on && !flags_r[F_TX_BUF_EMPTY_FLAG]);

  always_comb begin
    flag_set         = 8'h00;
    flag_set[F_TX_BUF_EMPTY_FLAG] = take && !wr_data;
    flag_set[F_TC]   = tx_act_d_r && !tx_act;
    flag_set[F_RX_FULL_FLAG] = accept && !flags_r[F_RX_FULL_FLAG];
    flag_set[F_OVR]  = accept && flags_r[F_RX_FULL_FLAG];
    flag_set[F_IDLE] = rx_on && rx_idle && !rx_sleep;
    flag_set[F_NF]   = accept && rx_nf;
    flag_set[F_FE]   = accept && rx_fe;
    flag_set[F_PF]   = accept && rx_pe;
  end

  always_comb begin
    flag_clr         = {8{wr_data}} & arm_r;
    flag_clr[F_TX_BUF_EMPTY_FLAG] = flag_clr[F_TX_BUF_EMPTY_FLAG] | wr_data;
    flag_clr[F_TC]   = flag_clr[F_TC] | tx_act;
    flag_clr[F_PF]   = flag_clr[F_PF] | rd_stat1;
  end

  // A flag event other than a take during a data write survives a clear in the same cycle
  assign flags_nxt = flag_set | (flags_r & ~flag_clr);

  wire irq_nxt = (flags_r[F_TX_BUF_EMPTY_FLAG] && ctrl_two_r[C2_TIE]) ||
                 (flags_r[F_TC] && ctrl_two_r[C2_TX_DONE_IRQ_EN]) ||
                 (!rx_sleep && ctrl_two_r[C2_RIE] &&
                  (flags_r[F_RX_FULL_FLAG] || flags_r[F_OVR])) ||
                 (!rx_sleep && ctrl_two_r[C2_IDLE_IRQ_EN] && flags_r[F_IDLE]);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_addr_r <= '0;
      aw_hold_r <= 1'b0;
      w_data_r  <= 32'h0;
      w_strb_r  <= 4'h0;
      w_hold_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      rvalid_r  <= 1'b0;
      rresp_r   <= RESP_OKAY;
      rdata_r   <= 32'h0;
    end else if (ce) begin
      if (aw_hs) aw_addr_r <= s_axi_awaddr;
      if (w_hs) w_data_r <= s_axi_wdata;
      if (w_hs) w_strb_r <= s_axi_wstrb;
      aw_hold_r <= do_wr ? 1'b0 : (aw_hold_r || aw_hs);
      w_hold_r  <= do_wr ? 1'b0 : (w_hold_r || w_hs);
      if (do_wr) begin
        bvalid_r <= 1'b1;
        bresp_r  <= aw_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) bvalid_r <= 1'b0;
      if (ar_hs) begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_val;
        rresp_r  <= ar_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) rvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      baud_r     <= BAUD_RST;
      ctrl_one_r <= CTRL_RST;
      tdr_r      <= 9'h000;
      baud_cnt_r <= 13'h0000;
    end else if (ce) begin
      if (wr_baud) baud_r <= m_baud[12:0];
      if (wr_c1) ctrl_one_r <= m_c1[7:0];
      if (wr_data) tdr_r <= m_dat[8:0];
      baud_cnt_r <= tick ? 13'h0000 : baud_cnt_r + 13'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_two_r <= CTRL_RST;
    end else if (ce) begin
      if (wr_c2) ctrl_two_r <= m_c2[7:0];
      else if (hw_wake) ctrl_two_r[C2_RWU] <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r    <= STAT1_RST;
      arm_r      <= 8'h00;
      rdr_r      <= 9'h000;
      tx_act_d_r <= 1'b0;
      irq_r      <= 1'b0;
    end else if (ce) begin
      flags_r    <= flags_nxt;
      arm_r      <= rd_stat1 ? flags_r : (wr_data ? 8'h00 : arm_r);
      if (flag_set[F_RX_FULL_FLAG]) rdr_r <= rx_data;
      tx_act_d_r <= tx_act;
      irq_r      <= irq_nxt;
    end
  end

  // Two-stage synchroniser; only the second stage feeds the receiver
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxd_m_r <= 1'b1;
      rxd_s_r <= 1'b1;
    end else if (ce) begin
      rxd_m_r <= rxd;
      rxd_s_r <= rxd_m_r;
    end
  end

  ser_tx u_tx (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .ce         (ce),
    .tick       (tick),
    .tx_on      (tx_on),
    .break_send (ctrl_two_r[C2_SBK]),
    .brk_req    (brk_req),
    .word9      (word9),
    .parity_on  (parity_on),
    .parity_odd (parity_odd),
    .data_ok    (!flags_r[F_TX_BUF_EMPTY_FLAG]),
    .data       (tdr_r),
    .take       (take),
    .busy       (tx_busy),
    .txd        (txd)
  );

  ser_rx u_rx (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .ce         (ce),
    .tick       (tick),
    .rxd        (rxd_s_r),
    .rx_on      (rx_on),
    .word9      (word9),
    .parity_on  (parity_on),
    .parity_odd (parity_odd),
    .done_r     (rx_done),
    .data_r     (rx_data),
    .fe_r       (rx_fe),
    .nf_r       (rx_nf),
    .pe_r       (rx_pe),
    .idle_r     (rx_idle),
    .active     (rx_act)
  );

  sequence s_read_ovr;
    rd_stat1 && flags_r[F_OVR];
  endsequence
  // Software may leave any gap between the status read and the data write
  sequence s_write_clr;
    wr_data && arm_r[F_OVR] && !flag_set[F_OVR];
  endsequence

  chk_clear_sequence: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_write_clr |=> !flags_r[F_OVR])
    else $error("overrun flag survived read-write clear");
  chk_clear_armed: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ce && s_read_ovr) |=> arm_r[F_OVR]) else $error("overrun flag not armed by read");
  chk_empty_on_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_data |=> !flags_r[F_TX_BUF_EMPTY_FLAG]) else $error("empty flag set after data write");
  chk_done_busy: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ce && tx_act) |=> !flags_r[F_TC]) else $error("done flag set while busy");
  chk_full_transfer: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ce && accept && !flags_r[F_RX_FULL_FLAG]) |=> (flags_r[F_RX_FULL_FLAG] && rdr_r == $past(rx_data)))
    else $error("character not moved to holding register");
  chk_overrun_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ce && accept && flags_r[F_RX_FULL_FLAG]) |=> flags_r[F_OVR]) else $error("overrun missed");
  chk_sleep_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (rx_sleep && !(flags_r[F_TX_BUF_EMPTY_FLAG] && ctrl_two_r[C2_TIE]) &&
     !(flags_r[F_TC] && ctrl_two_r[C2_TX_DONE_IRQ_EN])) |-> !irq_nxt)
    else $error("receiver request while asleep");
  chk_parity_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (rd_stat1 && !flag_set[F_PF]) |=> !flags_r[F_PF]) else $error("parity flag not cleared");
  chk_rx_disabled: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !rx_on |=> !$rose(flags_r[F_RX_FULL_FLAG])) else $error("full flag set while receiver off");
endmodule

// ### hdl/ser_rx.sv
// Receive sampler: start search, three-sample majority, error checks
// and idle-line detection. Assumes rxd is already synchronised.
`timescale 1ns/10ps
module ser_rx
  import serial_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       tick,
  input  wire logic       rxd,
  input  wire logic       rx_on,
  input  wire logic       word9,
  input  wire logic       parity_on,
  input  wire logic       parity_odd,
  output logic            done_r,
  output logic [8:0]      data_r,
  output logic            fe_r,
  output logic            nf_r,
  output logic            pe_r,
  output logic            idle_r,
  output logic            active
);
  typedef enum logic {R_IDLE, R_FRAME} rx_state_t;
  rx_state_t   st_r;
  logic [3:0]  sub_r;
  logic [3:0]  idx_r;
  logic [2:0]  smp_r;
  logic [8:0]  sh_r;
  logic        nz_r;
  logic        arm_r;
  logic [7:0]  ones_r;
  wire [3:0] last  = (word9 ? LEN9 : LEN8) - 4'h1;
  wire [7:0] itks  = {word9 ? LEN9 : LEN8, 4'h0};
  wire       maj   = (smp_r[0] & smp_r[1]) | (smp_r[0] & smp_r[2]) | (smp_r[1] & smp_r[2]);
  wire       split = !(&smp_r) && (|smp_r);
  wire       bnd   = tick && (st_r == R_FRAME) && (sub_r == OVS_LAST);
  wire [8:0] dat   = word9 ? sh_r : {1'b0, sh_r[8:1]};
  wire       pbad  = parity_on && ((word9 ? ^sh_r : ^sh_r[8:1]) != parity_odd);
  assign active = (st_r == R_FRAME);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= R_IDLE;
      {sub_r, idx_r, smp_r, sh_r, nz_r, arm_r, ones_r} <= '0;
      {done_r, data_r, fe_r, nf_r, pe_r, idle_r} <= '0;
    end else if (ce) begin
      done_r <= 1'b0;
      idle_r <= 1'b0;
      if (!rx_on) begin
        st_r   <= R_IDLE;
        arm_r  <= 1'b0;
        ones_r <= 8'h00;
      end else begin
        case (st_r)
          R_IDLE: if (tick) begin
            ones_r <= rxd ? ones_r + 8'h01 : 8'h00;
            if (!rxd) begin
              st_r  <= R_FRAME;
              sub_r <= 4'h0;
              idx_r <= 4'h0;
              nz_r  <= 1'b0;
            end else if (arm_r && ones_r == itks - 8'h01) begin
              idle_r <= 1'b1;
              arm_r  <= 1'b0;
            end
          end
          R_FRAME: if (tick) begin
            sub_r <= sub_r + 4'h1;
            if (sub_r >= SMP_A && sub_r <= SMP_C) smp_r <= {rxd, smp_r[2:1]};
            if (bnd) begin
              nz_r  <= nz_r | split;
              idx_r <= idx_r + 4'h1;
              if (idx_r == 4'h0 && maj) st_r <= R_IDLE;
              else if (idx_r == last) begin
                st_r   <= R_IDLE;
                done_r <= 1'b1;
                data_r <= dat;
                fe_r   <= !maj;
                nf_r   <= nz_r | split;
                pe_r   <= pbad;
                arm_r  <= 1'b1;
                ones_r <= 8'h00;
              end else if (idx_r != 4'h0) sh_r <= {maj, sh_r[8:1]};
            end
          end
          default: st_r <= R_IDLE;
        endcase
      end
    end
  end
  chk_stop_framing: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ce && rx_on && bnd && idx_r == last && !maj) |=> (done_r && fe_r))
    else $error("framing error not reported");
endmodule

// ### hdl/ser_tx.sv
// Transmit sequencer: idle preamble, break frames and data frames.
// Assumes tick is a one-cycle pulse at sixteen times the bit rate.
`timescale 1ns/10ps
module ser_tx
  import serial_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       tick,
  input  wire logic       tx_on,
  input  wire logic       break_send,
  input  wire logic       brk_req,
  input  wire logic       word9,
  input  wire logic       parity_on,
  input  wire logic       parity_odd,
  input  wire logic       data_ok,
  input  wire logic [8:0] data,
  output logic            take,
  output logic            busy,
  output logic            txd
);
  logic [3:0]  sub_r;
  logic [10:0] sh_r;
  logic [3:0]  left_r;
  logic        on_d_r;
  logic        pre_r;
  logic        brk_r;
  wire [3:0]  len     = word9 ? LEN9 : LEN8;
  wire        bnd     = tick && (sub_r == OVS_LAST);
  wire        frm_end = bnd && (left_r <= 4'h1);
  wire        brk_go  = brk_r || break_send;
  wire        par     = (word9 ? ^data[7:0] : ^data[6:0]) ^ parity_odd;
  wire [8:0]  dp      = !parity_on ? data :
                        word9 ? {par, data[7:0]} : {1'b0, par, data[6:0]};
  wire [10:0] dfrm    = word9 ? {1'b1, dp, 1'b0} : {2'h3, dp[7:0], 1'b0};
  wire [10:0] bfrm    = word9 ? 11'h000 : 11'h400;
  assign take = tx_on && frm_end && !pre_r && !brk_go && data_ok;
  assign busy = (left_r != 4'h0) || pre_r || brk_r || (tx_on && break_send);
  assign txd  = sh_r[0];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sub_r  <= 4'h0;
      sh_r   <= 11'h7FF;
      left_r <= 4'h0;
      on_d_r <= 1'b0;
      pre_r  <= 1'b0;
      brk_r  <= 1'b0;
    end else if (ce) begin
      on_d_r <= tx_on;
      // Bit clock runs freely while enabled, so a short break pulse is held in brk_r until the next frame boundary
      sub_r  <= !tx_on ? 4'h0 : sub_r + {3'h0, tick};
      pre_r  <= tx_on && (!on_d_r || (pre_r && !frm_end));
      brk_r  <= tx_on && (brk_req || (brk_r && !(frm_end && !pre_r)));
      if (!tx_on) begin
        sh_r   <= 11'h7FF;
        left_r <= 4'h0;
      end else if (frm_end) begin
        left_r <= (pre_r || brk_go || data_ok) ? len : 4'h0;
        if (pre_r) sh_r <= 11'h7FF;
        else if (brk_go) sh_r <= bfrm;
        else if (data_ok) sh_r <= dfrm;
        else sh_r <= 11'h7FF;
      end else if (bnd && left_r != 4'h0) begin
        sh_r   <= {1'b1, sh_r[10:1]};
        left_r <= left_r - 4'h1;
      end
    end
  end
  chk_preamble_queued: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ce && tx_on && !on_d_r) |=> pre_r) else $error("preamble not queued");
  chk_break_queued: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ce && tx_on && brk_req) |=> brk_r) else $error("break not queued");
endmodule

// ### hdl/serial_pkg.sv
// Register map, field positions, reset values and sampling figures
// of the serial controller. Assumes a 32-bit AXI4-Lite host bus.
package serial_pkg;
  localparam logic [7:0] BAUD_OFS  = 8'h6C;
  localparam logic [7:0] CTRL1_OFS = 8'h70;
  localparam logic [7:0] STAT1_OFS = 8'h74;
  localparam logic [7:0] CTRL2_OFS = 8'h78;
  localparam logic [7:0] STAT2_OFS = 8'h7C;
  localparam logic [7:0] DATA_OFS  = 8'h80;
  // serial_status_one
  localparam int F_TX_BUF_EMPTY_FLAG = 7;
  localparam int F_TC   = 6;
  localparam int F_RX_FULL_FLAG = 5;
  localparam int F_IDLE = 4;
  localparam int F_OVR  = 3;
  localparam int F_NF   = 2;
  localparam int F_FE   = 1;
  localparam int F_PF   = 0;
  localparam logic [7:0] STAT1_RST = 8'hC0;
  // serial_control_two
  localparam int C2_TIE  = 7;
  localparam int C2_TX_DONE_IRQ_EN = 6;
  localparam int C2_RIE  = 5;
  localparam int C2_IDLE_IRQ_EN = 4;
  localparam int C2_TE   = 3;
  localparam int C2_RE   = 2;
  localparam int C2_RWU  = 1;
  localparam int C2_SBK  = 0;
  // Control one: word size, wake method, parity
  localparam int C1_M    = 4;
  localparam int C1_WAKE = 3;
  localparam int C1_PE   = 1;
  localparam int C1_PT   = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam int S2_RAF = 0;
  // Sixteen sample ticks per bit, majority of samples 7..9
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] SMP_A    = 4'h7;
  localparam logic [3:0] SMP_C    = 4'h9;
  localparam logic [3:0] LEN8     = 4'hA;
  localparam logic [3:0] LEN9     = 4'hB;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### verification/async_serial_ctrl_status_tb.sv
// Bench for the serial controller: AXI4-Lite master tasks and scenarios.
// Assumes serial_peer on the line and ce held high throughout.
`timescale 1ns/10ps
module async_serial_ctrl_status_tb;
  import serial_pkg::*;
  logic ref_clk = 0, rst_n = 0, ce = 1;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  // Response readies stay high, so back-to-back calls never re-drive them in one step
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1, s_axi_arvalid = 0;
  logic s_axi_rready = 1, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, rxd, txd, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] v;
  int errors = 0, n_tests = 0, cyc = 0;
  async_serial_ctrl_status uut (.*);
  serial_peer peer (.ref_clk(ref_clk), .txd(txd), .rxd(rxd));
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      close_out();
    end
  end
  task automatic close_out();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta = 0, tw = 0, aw, w, b;
    s_axi_awaddr <= a; s_axi_wdata <= d;
    s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    while (!(ta && tw)) begin
      #1 aw = s_axi_awready & !ta; w = s_axi_wready & !tw;
      @(posedge ref_clk);
      if (aw) begin s_axi_awvalid <= 0; ta = 1; end
      if (w) begin s_axi_wvalid <= 0; tw = 1; end
    end
    do begin #1 b = s_axi_bvalid; r = s_axi_bresp; @(posedge ref_clk); end while (!b);
  endtask
  task automatic rd(input logic [7:0] a);
    logic t = 0, rv;
    s_axi_araddr <= a; s_axi_arvalid <= 1;
    while (!t) begin #1 t = s_axi_arready; @(posedge ref_clk); end
    s_axi_arvalid <= 0;
    do begin #1 rv = s_axi_rvalid; v = s_axi_rdata; r = s_axi_rresp; @(posedge ref_clk);
    end while (!rv);
  endtask
  task automatic poll(input int b);
    for (int k = 0; k < 200; k++) begin rd(STAT1_OFS); if (v[b] === 1'b1) break; end
  endtask
  task automatic t_reset();
    rd(STAT1_OFS); chk("stat1 reset", {24'h0, STAT1_RST}, v);
    rd(8'h00); chk("unmapped resp", RESP_SLVERR, r);
    wr(BAUD_OFS, 32'h1);
    wr(CTRL2_OFS, 32'h0C);
    $display("t_reset done");
  endtask
  task automatic t_tx();
    wr(DATA_OFS, 32'h5A);
    rd(STAT1_OFS); chk("empty while preamble", 1'b0, v[F_TX_BUF_EMPTY_FLAG]);
    poll(F_TC);
    chk("done flag", 2'h3, v[7:6]);
    chk("tx frames", 1, peer.n_rx);
    chk("tx frame bits", 10'h2B4, peer.got);
    $display("t_tx done");
  endtask
  task automatic t_rx();
    fork
      peer.send(10'h34A);
      begin repeat (60) @(posedge ref_clk); rd(STAT2_OFS); chk("active", 1, v[S2_RAF]); end
    join
    poll(F_RX_FULL_FLAG); chk("full", 1, v[F_RX_FULL_FLAG]);
    rd(DATA_OFS); chk("rx data", 32'hA5, v);
    peer.send(10'h278);
    poll(F_OVR); chk("overrun", 1, v[F_OVR]);
    wr(DATA_OFS, 32'h11);
    rd(STAT1_OFS); chk("cleared", 2'h0, {v[F_RX_FULL_FLAG], v[F_OVR]});
    rd(STAT2_OFS); chk("inactive", 0, v[S2_RAF]);
    peer.send(10'h000);
    poll(F_FE); chk("framing", 1, v[F_FE]);
    $display("t_rx done");
  endtask
  task automatic t_brk();
    poll(F_TC);
    wr(CTRL2_OFS, 32'h0D);
    wr(CTRL2_OFS, 32'h0C);
    poll(F_TC); chk("break done", 1, v[F_TC]);
    chk("break frame", 10'h000, peer.got);
    $display("t_brk done");
  endtask
  task automatic t_irq();
    wr(CTRL2_OFS, 32'h8C);
    @(posedge ref_clk); #1 chk("irq on", 1, irq);
    wr(CTRL2_OFS, 32'h0C);
    @(posedge ref_clk); #1 chk("irq off", 0, irq);
    $display("t_irq done");
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1;
    @(posedge ref_clk);
    t_reset();
    t_tx();
    t_rx();
    t_brk();
    t_irq();
    close_out();
  end
endmodule

// ### verification/serial_peer.sv
// Remote serial node: sends frames on rxd, captures frames from txd.
// Assumes 16 clock cycles per bit (baud divisor 1).
`timescale 1ns/10ps
module serial_peer (
  input  wire logic ref_clk,
  input  wire logic txd,
  output logic      rxd
);
  logic [9:0] got;
  int         n_rx;
  initial begin
    rxd = 1'b1;
    n_rx = 0;
  end
  task automatic send(input logic [9:0] f);
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (16) @(posedge ref_clk);
    end
    rxd <= 1'b1;
  endtask
  // Stops at mid stop bit so a back-to-back start edge is not missed
  always begin
    @(negedge txd);
    repeat (8) @(posedge ref_clk);
    for (int i = 0; i < 10; i++) begin
      got[i] = txd;
      if (i < 9) repeat (16) @(posedge ref_clk);
    end
    n_rx++;
  end
endmodule
